// ### adc_sample_gain_offset_regs.sv
/*
  Gain and offset register bank for four sample streams with its correction
  datapath. Assumes an Avalon-MM master with byte addresses and one clock.
*/
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
module adc_sample_gain_offset_regs
  import gain_offset_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [addr_w-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [sample_w-1:0] sample_in,
  input wire logic sample_valid,
  input wire logic [1:0] sample_conv,
  input wire logic sample_odd,
  output logic [sample_w-1:0] sample_out,
  output logic sample_out_valid
);

  logic [15:0] gain_offset_conv6_even_q;
  logic [15:0] gain_offset_conv7_odd_q;
  logic [15:0] gain_offset_conv7_even_q;
  logic [15:0] gain_offset_conv8_odd_q;
  logic [15:0] cfg3_q;
  logic waitrequest_q;
  logic [31:0] readdata_q;
  logic [15:0] rd_word;
  logic [15:0] sel_reg;
  logic sel_hit;
  logic access_done;
  logic wr_cfg3;
  logic wr_conv6_even;
  logic wr_conv7_odd;
  logic wr_conv7_even;
  logic wr_conv8_odd;

  correction_cfg_if cfg_bus ();

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // a register answers only to its own aligned word address
  function automatic logic word_match(input logic [addr_w-1:0] a, input logic [5:0] idx);
    word_match = (a[1:0] == 2'h0) && (a[addr_w-1:2] == idx);
  endfunction

  // ----------------------------------------------------------------
  // bus slave: one wait state on every access
  // ----------------------------------------------------------------
  assign access_done = (read || write) && !waitrequest_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest_q <= 1'b1;
    end else if ((read || write) && waitrequest_q) begin
      waitrequest_q <= 1'b0;
    end else begin
      waitrequest_q <= 1'b1;
    end
  end

  // unmapped and misaligned words read as zero
  always_comb begin
    rd_word = 16'h0000;
    if (word_match(address, cfg3_idx)) begin
      rd_word = cfg3_q;
    end
    if (word_match(address, conv6_even_idx)) begin
      rd_word = gain_offset_conv6_even_q;
    end
    if (word_match(address, conv7_odd_idx)) begin
      rd_word = gain_offset_conv7_odd_q;
    end
    if (word_match(address, conv7_even_idx)) begin
      rd_word = gain_offset_conv7_even_q;
    end
    if (word_match(address, conv8_odd_idx)) begin
      rd_word = gain_offset_conv8_odd_q;
    end
  end

  // captured when the request is first seen, so it stands in the answer cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      readdata_q <= '0;
    end else if (read && waitrequest_q) begin
      readdata_q <= {16'h0000, rd_word};
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // a write lands only at the edge where the master sees waitrequest low
  assign wr_cfg3 = access_done && write && word_match(address, cfg3_idx);
  assign wr_conv6_even = access_done && write && word_match(address, conv6_even_idx);
  assign wr_conv7_odd = access_done && write && word_match(address, conv7_odd_idx);
  assign wr_conv7_even = access_done && write && word_match(address, conv7_even_idx);
  assign wr_conv8_odd = access_done && write && word_match(address, conv8_odd_idx);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg3_q <= reg_reset;
    end else if (wr_cfg3) begin
      cfg3_q <= merge(cfg3_q, writedata, byteenable) & cfg3_mask;
    end
  end

  // bit 10 is kept as written and steers nothing
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gain_offset_conv6_even_q <= reg_reset;
    end else if (wr_conv6_even) begin
      gain_offset_conv6_even_q <= merge(gain_offset_conv6_even_q, writedata, byteenable);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gain_offset_conv7_odd_q <= reg_reset;
    end else if (wr_conv7_odd) begin
      gain_offset_conv7_odd_q <= merge(gain_offset_conv7_odd_q, writedata, byteenable);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gain_offset_conv7_even_q <= reg_reset;
    end else if (wr_conv7_even) begin
      gain_offset_conv7_even_q <= merge(gain_offset_conv7_even_q, writedata, byteenable);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gain_offset_conv8_odd_q <= reg_reset;
    end else if (wr_conv8_odd) begin
      gain_offset_conv8_odd_q <= merge(gain_offset_conv8_odd_q, writedata, byteenable);
    end
  end

  // ----------------------------------------------------------------
  // per-sample selection
  // ----------------------------------------------------------------
  // streams without a register here pass through uncorrected
  always_comb begin
    sel_reg = reg_reset;
    sel_hit = 1'b0;
    if (sample_conv == conv6_sel && !sample_odd) begin
      sel_reg = gain_offset_conv6_even_q;
      sel_hit = 1'b1;
    end else if (sample_conv == conv7_sel && sample_odd) begin
      sel_reg = gain_offset_conv7_odd_q;
      sel_hit = 1'b1;
    end else if (sample_conv == conv7_sel && !sample_odd) begin
      sel_reg = gain_offset_conv7_even_q;
      sel_hit = 1'b1;
    end else if (sample_conv == conv8_sel && sample_odd) begin
      sel_reg = gain_offset_conv8_odd_q;
      sel_hit = 1'b1;
    end
  end

  assign cfg_bus.gain_code = sel_reg[gain_msb:gain_lsb];
  assign cfg_bus.offset = sel_reg[offset_msb:offset_lsb];
  assign cfg_bus.gain_on = sel_hit && cfg3_q[gain_en_bit];
  assign cfg_bus.offset_on = sel_hit && cfg3_q[offset_en_bit];

  correction_datapath u_correction_datapath (
    .clock(clock),
    .rst_b(rst_b),
    .cfg(cfg_bus),
    .sample_in(sample_in),
    .sample_valid(sample_valid),
    .sample_out_q(sample_out),
    .sample_out_valid_q(sample_out_valid)
  );

endmodule

// ### gain_offset_pkg.sv
/*
  Constants, register map and gain table for the per-sample gain and offset
  correction bank. Assumes a single 10 MHz clock and a 14-bit signed sample stream.
*/
package gain_offset_pkg;

  // ----------------------------------------------------------------
  // register map: printed offsets are indices, byte address = 4 * index
  // ----------------------------------------------------------------
  localparam logic [5:0] cfg3_idx = 6'h03;
  localparam logic [5:0] conv6_even_idx = 6'h1c;
  localparam logic [5:0] conv7_odd_idx = 6'h1d;
  localparam logic [5:0] conv7_even_idx = 6'h1e;
  localparam logic [5:0] conv8_odd_idx = 6'h1f;
  localparam int addr_w = 8;
  localparam logic [15:0] reg_reset = 16'h0000;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int gain_msb = 15;
  localparam int gain_lsb = 11;
  localparam int offset_msb = 9;
  localparam int offset_lsb = 0;
  localparam int gain_en_bit = 12;
  localparam int offset_en_bit = 8;
  localparam logic [15:0] cfg3_mask = 16'h1100;

  // ----------------------------------------------------------------
  // stream and datapath
  // ----------------------------------------------------------------
  localparam int sample_w = 14;
  localparam int coef_frac = 14;
  localparam int pipe_cycles = 2;
  localparam logic [1:0] conv6_sel = 2'h0;
  localparam logic [1:0] conv7_sel = 2'h1;
  localparam logic [1:0] conv8_sel = 2'h2;

  // linear gain 10^(N*0.01) with 14 fractional bits
  localparam logic [15:0] gain_table [32] = '{
    16'h4000, 16'h417e, 16'h4304, 16'h4494, 16'h462d, 16'h47cf, 16'h497b, 16'h4b32,
    16'h4cf2, 16'h4ebd, 16'h5092, 16'h5273, 16'h545e, 16'h5655, 16'h5858, 16'h5a67,
    16'h5c82, 16'h5eaa, 16'h60de, 16'h6320, 16'h656f, 16'h67cc, 16'h6a37, 16'h6cb0,
    16'h6f38, 16'h71cf, 16'h7476, 16'h772c, 16'h79f3, 16'h7cca, 16'h7fb2, 16'h82ac
  };

endpackage

// ### correction_cfg_if.sv
/*
  Carrier for the settings chosen for one incoming sample, from the register
  bank to the correction datapath. Assumes both ends share the one clock.
*/
`timescale 1ns/1ps
interface correction_cfg_if;
  logic [4:0] gain_code;
  logic [9:0] offset;
  logic gain_on;
  logic offset_on;

  modport bank (output gain_code, offset, gain_on, offset_on);
  modport datapath (input gain_code, offset, gain_on, offset_on);
endinterface

// ### correction_datapath.sv
/*
  Two-stage offset subtract then gain scale, saturating to 14 bits.
  Assumes the settings on the carrier are valid in the cycle the sample is taken.
*/
`timescale 1ns/1ps
module correction_datapath
  import gain_offset_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  correction_cfg_if.datapath cfg,
  input wire logic [sample_w-1:0] sample_in,
  input wire logic sample_valid,
  output logic [sample_w-1:0] sample_out_q,
  output logic sample_out_valid_q
);

  logic signed [sample_w:0] diff_q;
  logic [15:0] coef_q;
  logic valid1_q;
  logic signed [sample_w+17:0] product;
  logic signed [sample_w+3:0] scaled;

  function automatic logic [sample_w-1:0] saturate(input logic signed [sample_w+3:0] v);
    logic signed [sample_w+3:0] hi;
    logic signed [sample_w+3:0] lo;
    hi = (sample_w+4)'(2 ** (sample_w - 1) - 1);
    lo = -(sample_w+4)'(2 ** (sample_w - 1));
    if (v > hi) begin
      saturate = hi[sample_w-1:0];
    end else if (v < lo) begin
      saturate = lo[sample_w-1:0];
    end else begin
      saturate = v[sample_w-1:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // stage 1: offset
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      diff_q <= '0;
      coef_q <= gain_table[0];
      valid1_q <= 1'b0;
    end else begin
      valid1_q <= sample_valid;
      if (sample_valid) begin
        if (cfg.offset_on) begin
          // one offset unit is one sample lsb, sign extended
          diff_q <= {sample_in[sample_w-1], sample_in} - {{5{cfg.offset[9]}}, cfg.offset};
        end else begin
          diff_q <= {sample_in[sample_w-1], sample_in};
        end
        coef_q <= cfg.gain_on ? gain_table[cfg.gain_code] : gain_table[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // stage 2: gain and saturation
  // ----------------------------------------------------------------
  assign product = diff_q * $signed({2'b00, coef_q});
  // round to nearest before dropping the fraction
  assign scaled = (sample_w+4)'((product + (sample_w+18)'(2 ** (coef_frac - 1))) >>> coef_frac);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sample_out_q <= '0;
      sample_out_valid_q <= 1'b0;
    end else begin
      sample_out_valid_q <= valid1_q;
      if (valid1_q) begin
        sample_out_q <= saturate(scaled);
      end
    end
  end

endmodule

// ### adc_sample_gain_offset_regs_asserts.sv
/* port checker for the gain and offset bank.
   bound to the top module; assumes one clock and the bank's own enables. */
`timescale 1ns/1ps
module adc_sample_gain_offset_regs_asserts
  import gain_offset_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [addr_w-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [sample_w-1:0] sample_in,
  input wire logic sample_valid,
  input wire logic [1:0] sample_conv,
  input wire logic [sample_w-1:0] sample_out,
  input wire logic sample_out_valid
);
  // ------------------------------------------
  // enables seen on the bus
  // ------------------------------------------
  logic [1:0] en_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) en_q <= 2'h0;
    else if (write && !waitrequest && address == 8'h0c && byteenable[1])
      en_q <= {writedata[12], writedata[8]};
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wait_one_a: assert property (!waitrequest |=> waitrequest) else $error("wait low too long");
  answer_next_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer after one wait");
  answer_cause_a: assert property (!waitrequest |-> $past(read || write))
    else $error("answer without request");
  upper_zero_a: assert property (!waitrequest |-> readdata[31:16] == 16'h0)
    else $error("upper read half set");
  bad_addr_a: assert property (!waitrequest && read && address[1:0] != 2'h0 |-> readdata == 0)
    else $error("misaligned read not zero");
  out_latency_a: assert property (sample_valid |-> ##2 sample_out_valid)
    else $error("result not two cycles on");
  out_cause_a: assert property (sample_out_valid |-> $past(sample_valid, 2))
    else $error("result without sample");
  out_hold_a: assert property (!sample_out_valid |-> $stable(sample_out))
    else $error("result moved between valids");
  bypass_a: assert property (sample_valid && en_q == 2'h0 |->
    ##2 sample_out == $past(sample_in, 2)) else $error("correction applied while off");
  no_select_a: assert property (sample_valid && sample_conv == 2'h3 |->
    ##2 sample_out == $past(sample_in, 2)) else $error("unselected stream altered");
  cover property (write && !waitrequest);
  cover property (read && !waitrequest);
  cover property (sample_valid && en_q == 2'h3);
endmodule
bind adc_sample_gain_offset_regs adc_sample_gain_offset_regs_asserts
  u_adc_sample_gain_offset_regs_asserts (
  .clock(clock), .rst_b(rst_b), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .sample_in(sample_in), .sample_valid(sample_valid), .sample_conv(sample_conv),
  .sample_out(sample_out), .sample_out_valid(sample_out_valid));

// ### adc_sample_gain_offset_regs_tb_top.sv
/* self-checking bench for the gain and offset bank.
   assumes the package constants and a 100 ns clock. */
`timescale 1ns/1ps
module adc_sample_gain_offset_regs_tb_top
  import gain_offset_pkg::*;
;
  logic clock = 0, rst_b = 0, read = 0, write = 0, sample_valid = 0, sample_odd = 0;
  logic [7:0] address = 0;
  logic [31:0] writedata = 0;
  logic [3:0] byteenable = 0;
  logic [13:0] sample_in = 0;
  logic [1:0] sample_conv = 0;
  logic [31:0] readdata;
  logic waitrequest, sample_out_valid;
  logic [13:0] sample_out;
  logic [15:0] sh [5];
  logic [31:0] rd_q [$];
  logic [31:0] sm_q [$];
  int miscompares = 0, check_count = 0;
  localparam logic [7:0] addrs [7] = '{8'h0c, 8'h70, 8'h74, 8'h78, 8'h7c, 8'h40, 8'h71};
  initial forever #50 clock = ~clock;
  adc_sample_gain_offset_regs u_adc_sample_gain_offset_regs (.clock(clock), .rst_b(rst_b),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .sample_in(sample_in), .sample_valid(sample_valid), .sample_conv(sample_conv),
    .sample_odd(sample_odd), .sample_out(sample_out), .sample_out_valid(sample_out_valid));
  // ------------------------------------------
  // checking and verdict
  // ------------------------------------------
  task automatic compare(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic summarize;
    // a result that never came counts as a mismatch too
    miscompares += rd_q.size() + sm_q.size();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic int slot(input logic [7:0] a);
    if (a inside {8'h70, 8'h74, 8'h78, 8'h7c}) return (a - 8'h70) >> 2;
    return (a == 8'h0c) ? 4 : 5;
  endfunction
  // offset first, then gain, rounded half up and clipped to 14 bits
  function automatic logic [13:0] model(input logic [13:0] s, input logic [1:0] c, input logic o);
    int i, d, g, p;
    logic [15:0] r;
    i = (c == 2'h1) ? (o ? 1 : 2) : (c == 2'h0 && !o) ? 0 : (c == 2'h2 && o) ? 3 : 4;
    r = (i < 4) ? sh[i] : 16'h0;
    d = $signed(s) - (sh[4][8] ? $signed(r[9:0]) : 0);
    g = sh[4][12] ? gain_table[r[15:11]] : 16384;
    p = (d * g + 8192) >>> 14;
    if (p > 8191) p = 8191;
    if (p < -8192) p = -8192;
    return p[13:0];
  endfunction
  task automatic bus(input logic [7:0] a, input logic wr, input logic [15:0] d,
                     input logic [3:0] be);
    int s;
    s = slot(a);
    @(posedge clock);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {16'h0, d};
    byteenable <= be;
    if (!wr) rd_q.push_back(s < 5 ? {16'h0, sh[s]} : 32'h0);
    // no cycle count is assumed; only the watchdog ends a wait with no answer
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    read <= 0;
    write <= 0;
    if (wr && s < 5) begin
      if (be[0]) sh[s][7:0] = d[7:0];
      if (be[1]) sh[s][15:8] = d[15:8];
      sh[4] &= cfg3_mask;
    end
  endtask
  task automatic burst;
    logic [13:0] s;
    logic [1:0] c;
    logic o;
    for (int k = 0; k < 40; k++) begin
      @(posedge clock);
      s = (k < 2) ? 14'(14'h2000 - k) : 14'($urandom);
      c = 2'($urandom);
      o = 1'($urandom);
      sample_in <= s;
      sample_conv <= c;
      sample_odd <= o;
      sample_valid <= 1;
      sm_q.push_back({18'h0, model(s, c, o)});
    end
    @(posedge clock);
    sample_valid <= 0;
    repeat (3) @(posedge clock);
  endtask
  always @(posedge clock) begin
    if (read && waitrequest === 1'b0) compare(readdata, rd_q.pop_front());
    if (sample_out_valid === 1'b1) begin
      compare({18'h0, sample_out}, sm_q.pop_front());
    end
  end
  // a few hundred cycles are needed; twenty thousand means a hang
  initial begin
    #2000000;
    miscompares++;
    summarize();
  end
  // ------------------------------------------
  // main sequence
  // ------------------------------------------
  initial begin
    void'($urandom(32'h7a2d));
    foreach (sh[i]) sh[i] = reg_reset;
    repeat (5) @(posedge clock);
    rst_b <= 1;
    for (int n = 0; n < 32; n++) begin
      compare(gain_table[n], $rtoi(16384.0 * 10.0 ** (n / 100.0) + 0.5));
    end
    foreach (addrs[i]) bus(addrs[i], 0, 0, 0);
    for (int i = 0; i < 4; i++) bus(8'(8'h70 + 4 * i), 1, 16'($urandom), 4'h3);
    bus(8'h0c, 1, 16'hffff, 4'h3);
    bus(8'h74, 1, 16'hffff, 4'h1);
    bus(8'h40, 1, 16'hffff, 4'h3);
    bus(8'h72, 1, 16'hffff, 4'h3);
    foreach (addrs[i]) bus(addrs[i], 0, 0, 0);
    for (int e = 0; e < 4; e++) begin
      bus(8'h0c, 1, {3'h0, e[1], 3'h0, e[0], 8'h0}, 4'h2);
      burst();
    end
    @(posedge clock);
    rst_b <= 0;
    @(posedge clock);
    rst_b <= 1;
    foreach (sh[i]) sh[i] = reg_reset;
    bus(8'h70, 0, 0, 0);
    repeat (4) @(posedge clock);
    summarize();
  end
endmodule
